// *** pkg/host_port_cfg.svh ***
// What this block does
// R1 - Separate-address mode latches address from address pins
// R2 - Host holds latch strobe high in separate mode
// R3 - Multiplexed mode latches top address bit and shared lines
// R4 - Strobes ignored while chip select high
// R5 - Write strobe low performs register write
// R6 - Direction high reads, low writes
// R7 - Read strobe low returns register data
// R8 - Read data driven from data strobe fall
// R9 - Write data captured at data strobe rise
// R10 - Separate mode selects register from address pins
// R11 - Low address pins ignored when multiplexed
// R12 - Shared lines form bidirectional 8-bit data bus
// R13 - Multiplexed low address comes from shared lines
// R14 - Ready low once access completed
// R15 - Interrupt pin polarity selectable by config register
// R16 - Interrupt pin push-pull or open-drain selectable
// R17 - Interrupt pin usable as software output
// R18 - Interface select latched at reset, four codes
// R19 - Data lines driven only during selected read
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH

// ----------------------------------------
// Interface select codes
// ----------------------------------------
`define SEL_SEP_MUX      3'h2
`define SEL_SEP_DIRECT   3'h3
`define SEL_DIR_DIRECT   3'h4
`define SEL_DIR_MUX      3'h6

// ----------------------------------------
// Host-side register addresses
// ----------------------------------------
`define ADDR_IRQ_CFG     9'h0_1f0
`define ADDR_PORT_SEL    9'h0_1f1

// ----------------------------------------
// Interrupt configuration bits and reset
// ----------------------------------------
`define IRQ_BIT_HIGH     0
`define IRQ_BIT_OD       1
`define IRQ_BIT_GPO      2
`define IRQ_BIT_GPV      3
`define IRQ_CFG_RST      8'h00

// ----------------------------------------
// AHB register offsets
// ----------------------------------------
`define AHB_MIRROR_ADDR  12'h000
`define AHB_MIRROR_DATA  12'h004
`define AHB_STATUS       12'h008
`define AHB_IRQ_CFG      12'h00c

`define BOOT_LAST_CYCLE  2'h3

`endif

// *** pkg/host_port_pkg.sv ***
`default_nettype none
package host_port_pkg;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_busy = 2'b01,
    st_done = 2'b10
  } cycle_state_type;

  typedef struct packed {
    logic       active_high;
    logic       open_drain;
    logic       gpo_mode;
    logic       gpo_value;
  } irq_cfg_type;

  typedef struct packed {
    logic       cs_n;
    logic       wr_n;
    logic       rd_n;
    logic       ale;
  } strobe_type;
endpackage
`default_nettype wire

// *** rtl/parallel_register_host_port.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "host_port_cfg.svh"

module parallel_register_host_port
  import host_port_pkg::*;
#(
  parameter int ADDR_W = 9,
  parameter int DATA_W = 8
) (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // Parallel host pins
  input  wire logic [ADDR_W-1:0] addr_pin,
  input  wire logic [DATA_W-1:0] ad_in,
  output logic      [DATA_W-1:0] ad_out,
  output logic                   ad_oe,
  input  wire logic              ale,
  input  wire logic              cs_n,
  input  wire logic              wr_n,
  input  wire logic              data_strobe_n,
  input  wire logic [2:0]        host_port_select,
  output logic                   ready_n,
  // Interrupt pin
  input  wire logic              irq_event,
  output logic                   irq_out,
  output logic                   irq_oe,
  // AHB-Lite register side
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp
);

  // Decode below is fixed to these widths
  if (ADDR_W != 9 || DATA_W != 8) begin : g_bad_size
    $error("host port needs 9 address and 8 data bits");
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  strobe_type              stb_m_q, stb_q;
  logic [ADDR_W-1:0]       a_m_q, a_q;
  logic [DATA_W-1:0]       d_m_q, d_q;
  logic [2:0]              sel_m_q, sel_q;
  // Strobes reset inactive so release never looks like an access

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stb_m_q <= '1;
      stb_q   <= '1;
      a_m_q   <= '0;
      a_q     <= '0;
      d_m_q   <= '0;
      d_q     <= '0;
      sel_m_q <= '0;
      sel_q   <= '0;
    end else begin
      stb_m_q <= '{cs_n: cs_n, wr_n: wr_n, rd_n: data_strobe_n, ale: ale};
      stb_q   <= stb_m_q;
      a_m_q   <= addr_pin;
      a_q     <= a_m_q;
      d_m_q   <= ad_in;
      d_q     <= d_m_q;
      sel_m_q <= host_port_select;
      sel_q   <= sel_m_q;
    end
  end

  // ----------------------------------------
  // Mode latched while reset settles
  // ----------------------------------------
  // Reset can't sample pins, so the select is captured on the first
  // clocked cycles after release, before any access is accepted.
  logic [2:0] mode_q;
  logic [1:0] boot_q;
  logic       boot_done;
  assign boot_done = (boot_q == `BOOT_LAST_CYCLE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_q <= 2'h0;
      mode_q <= 3'h0;
    end else if (!boot_done) begin
      boot_q <= boot_q + 2'h1;
      mode_q <= sel_q;                                   // see R18
    end
  end

  // Unused codes leave mode_ok low and the port deaf
  logic dir_style, muxed, mode_ok;
  assign dir_style = (mode_q == `SEL_DIR_DIRECT) || (mode_q == `SEL_DIR_MUX);  // see R18
  assign muxed     = (mode_q == `SEL_SEP_MUX) || (mode_q == `SEL_DIR_MUX);     // see R18
  assign mode_ok   = boot_done && (dir_style || mode_q == `SEL_SEP_DIRECT ||
                                   mode_q == `SEL_SEP_MUX);

  // ----------------------------------------
  // Address latch
  // ----------------------------------------
  // Transparent while strobe high, holds on fall; in separate mode the
  // host normally ties it high, so the pins flow straight through.
  logic [ADDR_W-1:0] addr_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= '0;
    end else if (stb_q.ale) begin
      if (muxed) begin
        addr_q <= {a_q[ADDR_W-1], d_q};                  // see R3, R13, R11
      end else begin
        addr_q <= a_q;                                   // see R1, R10, R2
      end
    end
  end

  // ----------------------------------------
  // Cycle decode
  // ----------------------------------------
  logic sel_act, rd_act, wr_act, rd_strobe_q;
  assign sel_act = mode_ok && !stb_q.cs_n;               // see R4
  assign rd_act  = sel_act && (dir_style ? (!stb_q.rd_n && stb_q.wr_n)
                                         : !stb_q.rd_n); // see R6, R7, R8
  assign wr_act  = sel_act && (dir_style ? (!stb_q.rd_n && !stb_q.wr_n)
                                         : !stb_q.wr_n); // see R5, R6

  cycle_state_type state_q;
  logic            wr_dir_q;
  logic            wr_pulse;
  logic [7:0]      mirror_addr_q, mirror_data_q;
  irq_cfg_type     irq_cfg_q;
  logic [7:0]      reg_rdata;

  // Separate style writes on strobe assertion; direction style writes
  // at the strobe's rising edge, so data settle during the pulse.
  // A held strobe moves on to done first, so the rise is taken there too.
  assign wr_pulse = dir_style ? (state_q != st_idle && wr_dir_q && stb_q.rd_n)  // see R9
                              : (state_q == st_idle && wr_act);                 // see R5

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q  <= st_idle;
      wr_dir_q <= 1'b0;
    end else begin
      unique case (state_q)
        st_idle: begin
          wr_dir_q <= wr_act;
          if (rd_act || wr_act) begin
            state_q <= dir_style ? st_busy : st_done;
          end
        end
        st_busy: begin
          if (stb_q.rd_n || stb_q.cs_n) begin
            state_q <= st_idle;
          end else begin
            state_q <= st_done;
          end
        end
        st_done: begin
          if (!rd_act && !wr_act) begin
            state_q <= st_idle;
          end
        end
        default: state_q <= st_idle;
      endcase
    end
  end

  // Ready stands until the synced strobe or select drops

  // ----------------------------------------
  // Ready and data drivers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_n     <= 1'b1;
      rd_strobe_q <= 1'b0;
      ad_out      <= '0;
    end else begin
      ready_n     <= !((state_q == st_done) && (rd_act || wr_act));  // see R14
      rd_strobe_q <= rd_act;                                                      // see R8, R19
      if (rd_act) begin
        ad_out <= reg_rdata;                                                      // see R7, R12
      end
    end
  end
  assign ad_oe = rd_strobe_q && rd_act;                  // see R19, R12

  // ----------------------------------------
  // Host-visible registers
  // ----------------------------------------
  // Host bit layout: the struct's field order is not the byte's
  function automatic irq_cfg_type cfg_from_bits(input logic [3:0] b);
    irq_cfg_type c;
    c.active_high = b[`IRQ_BIT_HIGH];
    c.open_drain  = b[`IRQ_BIT_OD];
    c.gpo_mode    = b[`IRQ_BIT_GPO];
    c.gpo_value   = b[`IRQ_BIT_GPV];
    return c;
  endfunction

  function automatic logic [3:0] cfg_to_bits(input irq_cfg_type c);
    logic [3:0] b;
    b[`IRQ_BIT_HIGH] = c.active_high;
    b[`IRQ_BIT_OD]   = c.open_drain;
    b[`IRQ_BIT_GPO]  = c.gpo_mode;
    b[`IRQ_BIT_GPV]  = c.gpo_value;
    return b;
  endfunction

  always_comb begin
    unique case (addr_q)
      `ADDR_IRQ_CFG:  reg_rdata = {4'h0, cfg_to_bits(irq_cfg_q)};
      `ADDR_PORT_SEL: reg_rdata = {5'h00, mode_q};
      default:        reg_rdata = (addr_q[7:0] == mirror_addr_q) ? mirror_data_q : 8'h00;
    endcase
  end

  // ----------------------------------------
  // AHB side decode
  // ----------------------------------------
  logic        ahb_wr_q;
  logic [11:0] ahb_addr_q;
  logic        ahb_req;
  assign ahb_req = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ahb_wr_q   <= 1'b0;
      ahb_addr_q <= 12'h000;
    end else begin
      ahb_wr_q   <= ahb_req && hwrite;
      ahb_addr_q <= ahb_req ? haddr[11:0] : ahb_addr_q;
    end
  end

  // Host write wins; an AHB write in the same cycle is dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_cfg_q     <= cfg_from_bits(4'(`IRQ_CFG_RST));
      mirror_addr_q <= 8'h00;
      mirror_data_q <= 8'h00;
    end else if (wr_pulse) begin
      if (addr_q == `ADDR_IRQ_CFG) begin
        irq_cfg_q <= cfg_from_bits(d_q[3:0]);            // see R15, R16, R17
      end else begin
        mirror_addr_q <= addr_q[7:0];
        mirror_data_q <= d_q;                            // see R5, R9
      end
    end else if (ahb_wr_q) begin
      unique case (ahb_addr_q)
        `AHB_MIRROR_ADDR: mirror_addr_q <= hwdata[7:0];
        `AHB_MIRROR_DATA: mirror_data_q <= hwdata[7:0];
        `AHB_IRQ_CFG:     irq_cfg_q     <= cfg_from_bits(hwdata[3:0]);
        default:          ;
      endcase
    end
  end

  always_comb begin
    unique case (ahb_addr_q)
      `AHB_MIRROR_ADDR: hrdata = {24'h00_0000, mirror_addr_q};
      `AHB_MIRROR_DATA: hrdata = {24'h00_0000, mirror_data_q};
      `AHB_STATUS:      hrdata = {24'h00_0000, 2'h0, state_q, mode_ok, mode_q};
      `AHB_IRQ_CFG:     hrdata = {28'h000_0000, cfg_to_bits(irq_cfg_q)};
      default:          hrdata = 32'h0000_0000;
    endcase
  end
  // Zero wait: hrdata decodes the address taken in the address phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ----------------------------------------
  // Interrupt pin
  // ----------------------------------------
  // Open-drain only ever pulls low, so a high irq_level there is
  // realised by releasing the pin, and a low one by driving it low.
  logic irq_level;
  always_comb begin
    if (irq_cfg_q.gpo_mode) begin
      irq_level = irq_cfg_q.gpo_value;                   // see R17
    end else begin
      irq_level = irq_cfg_q.active_high ? irq_event : !irq_event;  // see R15
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_out <= 1'b0;
      irq_oe  <= 1'b0;
    end else begin
      irq_out <= irq_cfg_q.open_drain ? 1'b0 : irq_level;     // see R16
      irq_oe  <= irq_cfg_q.open_drain ? !irq_level : 1'b1;    // see R16
    end
  end

endmodule
`default_nettype wire

// *** sim/host_port_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module host_port_checker (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Host pins
  input wire logic [2:0] host_port_select,
  input wire logic       cs_n,
  input wire logic       wr_n,
  input wire logic       data_strobe_n,
  input wire logic       ready_n,
  input wire logic       ad_oe
);
  logic sel_ok;
  logic sel_sep;
  assign sel_ok = host_port_select inside {3'h2, 3'h3, 3'h4, 3'h6};
  assign sel_sep = host_port_select inside {3'h2, 3'h3};
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Pins cross a two-stage sync, so each bound leaves room for it
  sequence s_read_req;
    !cs_n && !data_strobe_n && wr_n;
  endsequence
  sequence s_sep_write;
    !cs_n && !wr_n && data_strobe_n;
  endsequence
  property p_idle_oe; cs_n [*6] |-> !ad_oe; endproperty
  a_idle_oe: assert property (p_idle_oe) else $error("lines driven while idle");
  property p_idle_rdy; cs_n [*6] |-> ready_n; endproperty
  a_idle_rdy: assert property (p_idle_rdy) else $error("ready while idle");
  property p_rdy_cause; $fell(ready_n) |-> !$past(cs_n, 2); endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("ready without select");
  property p_rd_ans; sel_ok ##0 s_read_req [*2] |-> ##[1:8] (!ready_n && ad_oe); endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_sep_wr; sel_sep ##0 s_sep_write [*2] |-> ##[1:8] !ready_n; endproperty
  a_sep_wr: assert property (p_sep_wr) else $error("write not answered");
  property p_wr_noe; (!wr_n) [*4] |-> !ad_oe; endproperty
  a_wr_noe: assert property (p_wr_noe) else $error("lines driven in write");
  property p_rel; $rose(cs_n) |-> ##[1:6] (ready_n && !ad_oe); endproperty
  a_rel: assert property (p_rel) else $error("ready held after release");
  property p_off; !sel_ok |-> ready_n && !ad_oe; endproperty
  a_off: assert property (p_off) else $error("port active in unused mode");
endmodule
bind parallel_register_host_port host_port_checker u_chk (.hclk(hclk), .hresetn(hresetn),
  .host_port_select(host_port_select), .cs_n(cs_n), .wr_n(wr_n),
  .data_strobe_n(data_strobe_n), .ready_n(ready_n), .ad_oe(ad_oe));
`default_nettype wire

// *** sim/host_bus_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
  // Clock and device side
  input  wire logic       hclk,
  input  wire logic [2:0] host_port_select,
  input  wire logic [7:0] ad_out,
  input  wire logic       ad_oe,
  input  wire logic       ready_n,
  // Host pins
  output logic      [8:0] addr_pin = 9'h000,
  output logic      [7:0] ad_in,
  output logic            ale = 1'b1,
  output logic            cs_n = 1'b1,
  output logic            wr_n = 1'b1,
  output logic            data_strobe_n = 1'b1
);
  logic [7:0] hd = 8'h00;
  logic       hoe = 1'b0;
  // No pull on these lines: floating shows the inverse of the last byte
  assign ad_in = ad_oe ? ad_out : (hoe ? hd : ~hd);
  task automatic xfer(input bit rd, input logic [8:0] a, input logic [7:0] d,
                      input logic [7:0] junk, output logic [7:0] q, output bit ok);
    bit mux;
    int n;
    mux = host_port_select[1] & ~host_port_select[0];
    ok = 1'b0;
    @(posedge hclk);
    ale <= 1'b1;
    addr_pin <= mux ? {a[8], junk} : a;
    hd <= mux ? a[7:0] : junk;
    hoe <= 1'b1;
    repeat (3) @(posedge hclk);
    ale <= !mux;
    @(posedge hclk);
    cs_n <= 1'b0;
    wr_n <= rd;
    data_strobe_n <= host_port_select[2] ? 1'b0 : !rd;
    hd <= d;
    hoe <= !rd;
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge hclk);
      ok = !ready_n;
    end
    q = ad_in;
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    data_strobe_n <= 1'b1;
    // Data held past the strobe rise for the synced capture
    repeat (4) @(posedge hclk);
    hoe <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** sim/parallel_register_host_port_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "host_port_cfg.svh"
module parallel_register_host_port_tb;
  logic        hclk, ad_oe, ready_n, ale, cs_n, wr_n, data_strobe_n;
  logic        irq_out, irq_oe, hreadyout, hresp;
  logic        hresetn = 1'b0;
  logic        irq_event = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [2:0]  host_port_select = 3'h2;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, r, seen;
  logic [8:0]  addr_pin, a;
  logic [7:0]  ad_in, ad_out, q, d;
  logic [2:0]  codes [4] = '{3'h2, 3'h3, 3'h4, 3'h6};
  bit          ok;
  int          err_total = 0;
  int          checked = 0;
  int          seed = 32'h046d;
  int          i;
  parallel_register_host_port dut (.hready(hreadyout), .*);
  host_bus_model hm (.*);
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task automatic chk(input string name, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic bus_wait;
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (n == 50) begin
      err_total++;
      wrap_up;
    end
  endtask
  task automatic ahb(input bit w, input logic [11:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0_0000, ad};
    hwrite <= w;
    bus_wait;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    bus_wait;
    rd = hrdata;
  endtask
  task automatic do_reset(input logic [2:0] code);
    hresetn <= 1'b0;
    host_port_select <= code;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
  endtask
  function automatic logic [1:0] irq_exp(input logic [3:0] c, input logic ev);
    logic v;
    v = c[2] ? c[3] : (c[0] ? ev : !ev);
    return c[1] ? {!v, 1'b0} : {1'b1, v};
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    foreach (codes[k]) begin
      do_reset(codes[k]);
      for (i = 0; i < 3; i++) begin
        r = $random(seed);
        a = r[8:0] & 9'h1ef;
        d = r[23:16];
        hm.xfer(1'b0, a, d, r[31:24], q, ok);
        chk("wr_ok", ok, 1);
        ahb(1'b0, `AHB_MIRROR_ADDR, 0, seen);
        chk("addr", seen[7:0], a[7:0]);
        ahb(1'b0, `AHB_MIRROR_DATA, 0, seen);
        chk("wdata", seen[7:0], d);
        hm.xfer(1'b1, a, 8'h00, r[15:8], q, ok);
        chk("rdata", q, d);
      end
      hm.xfer(1'b1, `ADDR_PORT_SEL, 8'h00, r[7:0], q, ok);
      chk("mode", q, {5'h00, codes[k]});
      ahb(1'b0, `AHB_STATUS, 0, seen);
      chk("status", seen[5:0], {3'h1, codes[k]});
    end
    ahb(1'b0, 12'h0f0, 0, seen);
    chk("unmapped", seen, 0);
    for (i = 0; i < 32; i++) begin
      r = $random(seed);
      if (i[0]) begin
        hm.xfer(1'b0, `ADDR_IRQ_CFG, {4'h0, i[3:0]}, r[7:0], q, ok);
        chk("cfg_wr_ok", ok, 1);
      end else begin
        ahb(1'b1, `AHB_IRQ_CFG, {28'h000_0000, i[3:0]}, seen);
      end
      irq_event <= i[4];
      repeat (3) @(posedge hclk);
      chk("irq_pin", {irq_oe, irq_out}, irq_exp(i[3:0], i[4]));
      ahb(1'b0, `AHB_IRQ_CFG, 0, seen);
      chk("irq_cfg", seen[3:0], i[3:0]);
    end
    do_reset(3'h0);
    hm.xfer(1'b1, 9'h000, 8'h00, 8'h00, q, ok);
    chk("off_ok", ok, 0);
    wrap_up;
  end
  initial begin
    #2_000_000;
    err_total++;
    wrap_up;
  end
endmodule
`default_nettype wire
